//--- rtl/cmb_pkg.sv
// Purpose: Shared constants of the CAN message buffer control block
// Assumes: 16-bit register port, word addresses
// Notes: Address bits 7:4 pick a buffer or, at 4'hF, the global page; bits 3:0 a register in it
package cmb_pkg;
  localparam logic [3:0] REG_DATA01 = 4'h0;
  localparam logic [3:0] REG_DATA67 = 4'h3;
  localparam logic [3:0] REG_LEN = 4'h4;
  localparam logic [3:0] REG_CONF = 4'h5;
  localparam logic [3:0] REG_IDL = 4'h6;
  localparam logic [3:0] REG_IDH = 4'h7;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] PAGE_GLOBAL = 4'hF;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQMASK = 4'h1;
  localparam logic [3:0] REG_MASKL = 4'h2;
  localparam logic [3:0] REG_MASKH = 4'h3;
  localparam int CTL_RDY = 0;
  localparam int CTL_TXREQ = 1;
  localparam int CTL_NEWDATA = 2;
  localparam int CTL_IRQEN = 3;
  localparam int CTL_OVWR = 4;
  localparam int CTL_SET = 8;
  localparam int CONF_TYPE_LSB = 3;
  localparam int CONF_RTR = 6;
  localparam int IDH_IDE = 15;
  localparam int ST_RX = 0;
  localparam int ST_TX = 1;
  localparam int ST_TXERR = 2;
  localparam int ST_W = 3;
  localparam logic [3:0] DLC_MAX = 4'h8;
  localparam logic [7:0] CONF_RST = 8'h00;
  localparam logic [28:0] MASK_RST = 29'h00000000;
  typedef enum logic [2:0] {
    CMB_TYPE_TX = 3'h0,
    CMB_TYPE_RX = 3'h1,
    CMB_TYPE_RXM = 3'h2
  } cmb_type_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_REQ = 2'h1,
    TX_BUSY = 2'h2
  } cmb_txst_t;
endpackage

//--- rtl/cmb_sel_if.sv
// Purpose: Carries buffer attributes to the filter and priority selector
// Assumes: Driven by the top module, answered combinationally
// Notes: None
`timescale 1ns/1ps
interface cmb_sel_if #(parameter int NBUF = 8, parameter int IW = 3);
  logic [28:0] bufId [NBUF];
  logic [NBUF-1:0] bufIde;
  logic [NBUF-1:0] bufRtr;
  logic [NBUF-1:0] rxCand;
  logic [NBUF-1:0] rxMasked;
  logic [NBUF-1:0] txCand;
  logic [28:0] maskId;
  logic [28:0] rxId;
  logic rxIde;
  logic rxHit;
  logic [IW-1:0] rxIdx;
  logic txHit;
  logic [IW-1:0] txIdx;
  modport filt(input bufId, bufIde, rxCand, rxMasked, maskId, rxId, rxIde,
    output rxHit, rxIdx);
  modport sel(input bufId, bufIde, bufRtr, txCand, output txHit, txIdx);
endinterface

//--- rtl/cmb_rx_filter.sv
// Purpose: Finds the receive buffer that accepts an incoming frame
// Assumes: Candidates are ready receive buffers
// Notes: Lowest buffer number wins when several match
`timescale 1ns/1ps
module cmb_rx_filter import cmb_pkg::*; #(parameter int NBUF = 8, parameter int IW = 3) (
  cmb_sel_if.filt sel
);
  logic [NBUF-1:0] match;
  genvar m;
  generate
    for (m = 0; m < NBUF; m++) begin : g_match
      logic [28:0] careBits;
      logic [28:0] diffBits;
      // Standard frames only carry the top eleven identifier bits
      assign careBits = (sel.rxMasked[m] ? ~sel.maskId : 29'h1FFFFFFF)
        & (sel.rxIde ? 29'h1FFFFFFF : 29'h1FFC0000);
      assign diffBits = (sel.bufId[m] ^ sel.rxId) & careBits;
      assign match[m] = sel.rxCand[m] && (sel.bufIde[m] == sel.rxIde)
        && (diffBits == 29'h00000000);
    end
  endgenerate
  always_comb begin
    sel.rxHit = 1'b0;
    sel.rxIdx = '0;
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (match[i]) begin
        sel.rxHit = 1'b1;
        sel.rxIdx = IW'(i);
      end
    end
  end
endmodule

//--- rtl/cmb_tx_select.sv
// Purpose: Picks the pending transmit buffer of highest bus priority
// Assumes: Candidates are ready buffers with a transmit request
// Notes: Ties go to the lower buffer number
`timescale 1ns/1ps
module cmb_tx_select import cmb_pkg::*; #(parameter int NBUF = 8, parameter int IW = 3) (
  cmb_sel_if.sel sel
);
  // Arbitration order packed so that the smaller key wins
  function automatic logic [30:0] prioKey(input logic [28:0] id, input logic ide,
    input logic rtr);
    prioKey = {id[28:18], ide, (ide ? id[17:0] : 18'h00000), rtr};
  endfunction
  always_comb begin
    logic [30:0] bestKey;
    bestKey = '1;
    sel.txHit = 1'b0;
    sel.txIdx = '0;
    for (int i = 0; i < NBUF; i++) begin
      if (sel.txCand[i] && (!sel.txHit
          || prioKey(sel.bufId[i], sel.bufIde[i], sel.bufRtr[i]) < bestKey)) begin
        sel.txHit = 1'b1;
        sel.txIdx = IW'(i);
        bestKey = prioKey(sel.bufId[i], sel.bufIde[i], sel.bufRtr[i]);
      end
    end
  end
endmodule

//--- rtl/cmb_msgbuf_ctrl.sv
// Purpose: Message buffer handling of a CAN controller, register side and
//   link to the protocol engine
// Assumes: Protocol engine runs on sys_clk; rxValid, txAccept and txDone
//   are one-cycle pulses
// Notes:
`timescale 1ns/1ps
module cmb_msgbuf_ctrl import cmb_pkg::*; #(
  parameter int NBUF = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic rxValid,
  input wire logic [28:0] rxId,
  input wire logic rxIde,
  input wire logic [3:0] rxDlc,
  input wire logic [63:0] rxData,
  input wire logic busBusy,
  output logic txReq,
  output logic [28:0] txId,
  output logic txIde,
  output logic txRtr,
  output logic [3:0] txDlc,
  output logic [63:0] txData,
  input wire logic txAccept,
  input wire logic txDone,
  input wire logic txOk,
  output logic irq
);
  localparam int IW = (NBUF > 1) ? $clog2(NBUF) : 1;

  // Buffer storage
  logic [28:0] idFf [NBUF];
  logic [NBUF-1:0] ideFf;
  logic [7:0] confFf [NBUF];
  logic [3:0] dlcFf [NBUF];
  logic [7:0] dataFf [NBUF][8];
  logic [NBUF-1:0] rdyFf;
  logic [NBUF-1:0] sendFf;
  logic [NBUF-1:0] newDataFf;
  logic [NBUF-1:0] irqEnFf;
  logic [NBUF-1:0] ovwrFf;

  // Global registers
  logic [28:0] maskFf;
  logic [ST_W-1:0] statusFf;
  logic [ST_W-1:0] irqMaskFf;
  logic [15:0] regRdataFf;

  // Transmit sequencing
  cmb_txst_t txStFf;
  cmb_txst_t nxt_txSt;
  logic [IW-1:0] txBufFf;
  logic [28:0] txIdFf;
  logic txIdeFf;
  logic txRtrFf;
  logic [3:0] txDlcFf;
  logic [63:0] txDataFf;

  // Address decode
  logic [3:0] pageSel;
  logic [3:0] regSel;
  logic bufPage;
  logic globPage;
  logic [IW-1:0] bufIdx;
  assign pageSel = regAddr[7:4];
  assign regSel = regAddr[3:0];
  assign bufPage = (32'(pageSel) < NBUF);
  assign globPage = (pageSel == PAGE_GLOBAL);
  assign bufIdx = IW'(pageSel);

  // Frame store for the buffer picked by the filter
  logic rxStore;
  logic [3:0] rxBytes;
  logic txEnd;
  assign rxBytes = (rxDlc > DLC_MAX) ? DLC_MAX : rxDlc;
  assign txEnd = (txStFf == TX_BUSY) && txDone;

  cmb_sel_if #(.NBUF(NBUF), .IW(IW)) selIf ();

  genvar m;
  generate
    for (m = 0; m < NBUF; m++) begin : g_buf
      logic wrHere;
      logic storeHere;
      logic txBusyHere;
      logic doneHere;
      cmb_type_t bufType;
      assign wrHere = regWr && bufPage && (bufIdx == IW'(m));
      assign storeHere = rxStore && (selIf.rxIdx == IW'(m));
      assign txBusyHere = (txStFf != TX_IDLE) && (txBufFf == IW'(m));
      assign doneHere = txEnd && (txBufFf == IW'(m));
      assign bufType = cmb_type_t'(confFf[m][CONF_TYPE_LSB +: 3]);

      assign selIf.bufId[m] = idFf[m];
      assign selIf.bufIde[m] = ideFf[m];
      assign selIf.bufRtr[m] = confFf[m][CONF_RTR];
      assign selIf.rxCand[m] = rdyFf[m]
        && (bufType == CMB_TYPE_RX || bufType == CMB_TYPE_RXM);
      assign selIf.rxMasked[m] = (bufType == CMB_TYPE_RXM);
      assign selIf.txCand[m] = rdyFf[m] && sendFf[m] && (bufType == CMB_TYPE_TX);

      // Ready: a clear aimed at the buffer on the bus is held off
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          rdyFf[m] <= 1'b0;
        end else if (wrHere && regSel == REG_CTRL && regWdata[CTL_SET + CTL_RDY]) begin
          rdyFf[m] <= 1'b1;
        end else if (wrHere && regSel == REG_CTRL && regWdata[CTL_RDY]
                     && !txBusyHere) begin
          rdyFf[m] <= 1'b0;
        end
      end

      // Transmit request: dropped by success, kept for retry on failure
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          sendFf[m] <= 1'b0;
        end else if (wrHere && regSel == REG_CTRL && regWdata[CTL_SET + CTL_TXREQ]) begin
          sendFf[m] <= 1'b1;
        end else if (wrHere && regSel == REG_CTRL && regWdata[CTL_TXREQ]) begin
          sendFf[m] <= 1'b0;
        end else if (doneHere && txOk) begin
          sendFf[m] <= 1'b0;
        end
      end

      // New data and overwrite: hardware set wins over a software clear
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          newDataFf[m] <= 1'b0;
          ovwrFf[m] <= 1'b0;
        end else begin
          if (storeHere) begin
            newDataFf[m] <= 1'b1;
          end else if (wrHere && regSel == REG_CTRL && regWdata[CTL_NEWDATA]) begin
            newDataFf[m] <= 1'b0;
          end
          if (storeHere && newDataFf[m]) begin
            ovwrFf[m] <= 1'b1;
          end else if (wrHere && regSel == REG_CTRL && regWdata[CTL_OVWR]) begin
            ovwrFf[m] <= 1'b0;
          end
        end
      end

      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          irqEnFf[m] <= 1'b0;
        end else if (wrHere && regSel == REG_CTRL && regWdata[CTL_SET + CTL_IRQEN]) begin
          irqEnFf[m] <= 1'b1;
        end else if (wrHere && regSel == REG_CTRL && regWdata[CTL_IRQEN]) begin
          irqEnFf[m] <= 1'b0;
        end
      end

      // Configuration is software only
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          confFf[m] <= CONF_RST;
        end else if (wrHere && regSel == REG_CONF) begin
          confFf[m] <= regWdata[7:0];
        end
      end

      // Identifier and length: a stored frame overrides a same-cycle write
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          idFf[m] <= 29'h00000000;
          ideFf[m] <= 1'b0;
          dlcFf[m] <= 4'h0;
        end else if (storeHere) begin
          idFf[m] <= rxId;
          ideFf[m] <= rxIde;
          dlcFf[m] <= rxDlc;
        end else if (wrHere) begin
          if (regSel == REG_IDL) begin
            idFf[m][15:0] <= regWdata;
          end
          if (regSel == REG_IDH) begin
            idFf[m][28:16] <= regWdata[12:0];
            ideFf[m] <= regWdata[IDH_IDE];
          end
          if (regSel == REG_LEN) begin
            dlcFf[m] <= regWdata[3:0];
          end
        end
      end

      // Data bytes beyond the received length keep their old contents
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          for (int b = 0; b < 8; b++) begin
            dataFf[m][b] <= 8'h00;
          end
        end else if (storeHere) begin
          for (int b = 0; b < 8; b++) begin
            if (4'(b) < rxBytes) begin
              dataFf[m][b] <= rxData[8*b +: 8];
            end
          end
        end else if (wrHere && regSel <= REG_DATA67) begin
          dataFf[m][{regSel[1:0], 1'b0}] <= regWdata[7:0];
          dataFf[m][{regSel[1:0], 1'b1}] <= regWdata[15:8];
        end
      end
    end
  endgenerate

  assign selIf.maskId = maskFf;
  assign selIf.rxId = rxId;
  assign selIf.rxIde = rxIde;
  assign rxStore = rxValid && selIf.rxHit;

  cmb_rx_filter #(.NBUF(NBUF), .IW(IW)) u_filter (
    .sel(selIf.filt)
  );

  cmb_tx_select #(.NBUF(NBUF), .IW(IW)) u_select (
    .sel(selIf.sel)
  );

  // Transmit sequencer
  always_comb begin
    nxt_txSt = txStFf;
    case (txStFf)
      TX_IDLE: begin
        if (selIf.txHit && !busBusy) begin
          nxt_txSt = TX_REQ;
        end
      end
      TX_REQ: begin
        if (txAccept) begin
          nxt_txSt = TX_BUSY;
        end else if (busBusy || !sendFf[txBufFf]) begin
          // Another node took the bus, or the request was withdrawn
          nxt_txSt = TX_IDLE;
        end
      end
      TX_BUSY: begin
        if (txDone) begin
          nxt_txSt = TX_IDLE;
        end
      end
      default: begin
        nxt_txSt = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txStFf <= TX_IDLE;
    end else begin
      txStFf <= nxt_txSt;
    end
  end

  // Frame contents frozen when offered, so later writes cannot tear it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txBufFf <= '0;
      txIdFf <= 29'h00000000;
      txIdeFf <= 1'b0;
      txRtrFf <= 1'b0;
      txDlcFf <= 4'h0;
      txDataFf <= 64'h0000000000000000;
    end else if (txStFf == TX_IDLE && nxt_txSt == TX_REQ) begin
      txBufFf <= selIf.txIdx;
      txIdFf <= idFf[selIf.txIdx];
      txIdeFf <= ideFf[selIf.txIdx];
      txRtrFf <= confFf[selIf.txIdx][CONF_RTR];
      txDlcFf <= dlcFf[selIf.txIdx];
      for (int b = 0; b < 8; b++) begin
        txDataFf[8*b +: 8] <= dataFf[selIf.txIdx][b];
      end
    end
  end

  assign txReq = (txStFf == TX_REQ);
  assign txId = txIdFf;
  assign txIde = txIdeFf;
  assign txRtr = txRtrFf;
  assign txDlc = txDlcFf;
  assign txData = txDataFf;

  // Global registers
  logic wrGlob;
  assign wrGlob = regWr && globPage;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      maskFf <= MASK_RST;
      irqMaskFf <= '0;
    end else if (wrGlob) begin
      if (regSel == REG_MASKL) begin
        maskFf[15:0] <= regWdata;
      end
      if (regSel == REG_MASKH) begin
        maskFf[28:16] <= regWdata[12:0];
      end
      if (regSel == REG_IRQMASK) begin
        irqMaskFf <= regWdata[ST_W-1:0];
      end
    end
  end

  // Sticky events, only from buffers with their interrupt enabled
  logic [ST_W-1:0] evt;
  assign evt[ST_RX] = rxStore && irqEnFf[selIf.rxIdx];
  assign evt[ST_TX] = txEnd && txOk && irqEnFf[txBufFf];
  assign evt[ST_TXERR] = txEnd && !txOk && irqEnFf[txBufFf];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      statusFf <= '0;
    end else begin
      statusFf <= evt
        | (statusFf & ~((wrGlob && regSel == REG_STATUS) ? regWdata[ST_W-1:0] : '0));
    end
  end

  assign irq = |(statusFf & irqMaskFf);

  // Read port: data valid only in the cycle after the strobe
  logic [15:0] rdMux;
  always_comb begin
    rdMux = 16'h0000;
    if (bufPage) begin
      case (regSel)
        REG_LEN: rdMux = {12'h000, dlcFf[bufIdx]};
        REG_CONF: rdMux = {8'h00, confFf[bufIdx]};
        REG_IDL: rdMux = idFf[bufIdx][15:0];
        REG_IDH: rdMux = {ideFf[bufIdx], 2'b00, idFf[bufIdx][28:16]};
        REG_CTRL: rdMux = {11'h000, ovwrFf[bufIdx], irqEnFf[bufIdx], newDataFf[bufIdx],
          sendFf[bufIdx], rdyFf[bufIdx]};
        default: begin
          if (regSel <= REG_DATA67) begin
            rdMux = {dataFf[bufIdx][{regSel[1:0], 1'b1}],
              dataFf[bufIdx][{regSel[1:0], 1'b0}]};
          end
        end
      endcase
    end else if (globPage) begin
      case (regSel)
        REG_STATUS: rdMux = {13'h0000, statusFf};
        REG_IRQMASK: rdMux = {13'h0000, irqMaskFf};
        REG_MASKL: rdMux = maskFf[15:0];
        REG_MASKH: rdMux = {3'b000, maskFf[28:16]};
        default: rdMux = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdataFf <= 16'h0000;
    end else if (regRd) begin
      regRdataFf <= rdMux;
    end else begin
      regRdataFf <= 16'h0000;
    end
  end

  assign regRdata = regRdataFf;
endmodule

//--- verif/cmb_msgbuf_ctrl_chk.sv
// Purpose: Port-level checks of the message buffer control block
// Assumes: Partner raises busBusy in the same cycle as its txAccept pulse
// Notes: Bound into every instance of the top module
`timescale 1ns/1ps
module cmb_msgbuf_ctrl_chk #(parameter int NBUF = 8) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  input wire logic rxValid,
  input wire logic busBusy,
  input wire logic txReq,
  input wire logic [28:0] txId,
  input wire logic txIde,
  input wire logic txRtr,
  input wire logic [3:0] txDlc,
  input wire logic [63:0] txData,
  input wire logic txAccept,
  input wire logic txDone,
  input wire logic irq
);
  logic txActive_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txActive_ff <= 1'b0;
    end else if (txAccept) begin
      txActive_ff <= 1'b1;
    end else if (txDone) begin
      txActive_ff <= 1'b0;
    end
  end
  rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0)
    else $error("read data without a read");
  unmapped_zero_a: assert property (regRd && regAddr[7:4] != 4'hF
    && int'(regAddr[7:4]) >= NBUF |=> regRdata == 16'h0) else $error("unmapped read not zero");
  busy_holds_a: assert property (busBusy |=> !txReq)
    else $error("frame offered while bus busy");
  start_idle_a: assert property ($rose(txReq) |-> !$past(busBusy))
    else $error("offer started on busy bus");
  accept_drops_a: assert property (txAccept |=> !txReq)
    else $error("offer kept after accept");
  frame_stable_a: assert property (txReq ##1 txReq
    |-> $stable({txId, txIde, txRtr, txDlc, txData})) else $error("offered frame changed");
  no_abort_a: assert property (txActive_ff |-> !txReq)
    else $error("new offer during transmission");
  done_idle_a: assert property (txDone |=> !txReq)
    else $error("offer in cycle after done");
  irq_cause_a: assert property ($changed(irq) |-> $past(regWr) || $past(rxValid) || $past(txDone))
    else $error("interrupt changed without cause");
  cover property (rxValid);
  cover property (txReq && txAccept);
  cover property ($rose(irq));
endmodule
bind cmb_msgbuf_ctrl cmb_msgbuf_ctrl_chk #(.NBUF(NBUF)) u_chk (.sys_clk, .arst_n, .regAddr,
  .regWr, .regRd, .regRdata, .rxValid, .busBusy, .txReq, .txId, .txIde, .txRtr, .txDlc,
  .txData, .txAccept, .txDone, .irq);

//--- verif/cmb_can_node.sv
// Purpose: Behavioural model of the other nodes and protocol engine
// Assumes: Any offered frame is taken while the bus is free
// Notes: Receive fields are garbled outside the valid pulse
`timescale 1ns/1ps
module cmb_can_node #(parameter int TXLEN = 6) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic txReq,
  input wire logic holdBusy,
  input wire logic failNext,
  output logic txAccept,
  output logic txDone,
  output logic txOk,
  output logic busBusy,
  output logic rxValid,
  output logic [28:0] rxId,
  output logic rxIde,
  output logic [3:0] rxDlc,
  output logic [63:0] rxData
);
  int txCnt;
  int rxCnt;
  logic qPend;
  logic [28:0] qId;
  logic [3:0] qDlc;
  logic [63:0] qData;
  // Any frame on the wire keeps the bus busy
  assign busBusy = holdBusy || txCnt != 0 || rxCnt != 0;
  task automatic send(input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] d);
    qId = id;
    qDlc = dlc;
    qData = d;
    qPend = 1'b1;
  endtask
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txCnt <= 0;
      rxCnt <= 0;
      qPend <= 1'b0;
      txAccept <= 1'b0;
      txDone <= 1'b0;
      txOk <= 1'b0;
      rxValid <= 1'b0;
      rxId <= 29'h0;
      rxIde <= 1'b0;
      rxDlc <= 4'h0;
      rxData <= 64'h0;
    end else begin
      txAccept <= txReq && !busBusy;
      txDone <= txCnt == 1;
      txOk <= txCnt == 1 ? !failNext : ~txOk;
      if (txReq && !busBusy) begin
        txCnt <= TXLEN;
      end else if (txCnt != 0) begin
        txCnt <= txCnt - 1;
      end
      if (qPend && !busBusy && !txReq) begin
        rxCnt <= 3;
        qPend <= 1'b0;
      end else if (rxCnt != 0) begin
        rxCnt <= rxCnt - 1;
      end
      rxValid <= rxCnt == 1;
      // Toggling stale fields stops old values passing for new ones
      rxId <= rxCnt == 1 ? qId : ~rxId;
      rxIde <= rxCnt == 1 ? 1'b0 : ~rxIde;
      rxDlc <= rxCnt == 1 ? qDlc : ~rxDlc;
      rxData <= rxCnt == 1 ? qData : ~rxData;
    end
  end
endmodule

//--- verif/cmb_msgbuf_ctrl_tb.sv
// Purpose: Self-checking bench of the message buffer control block
// Assumes: Eight buffers, partner takes frames at once
// Notes: Register round trips run from a table
`timescale 1ns/1ps
module cmb_msgbuf_ctrl_tb;
  typedef struct packed {logic [7:0] a; logic [15:0] w; logic [15:0] e;} cmb_row_t;
  logic sys_clk, arst_n, regWr, regRd, rxValid, rxIde, busBusy, txReq, txIde, txRtr;
  logic txAccept, txDone, txOk, irq, holdBusy, failNext;
  logic [7:0] regAddr;
  logic [15:0] regWdata, regRdata;
  logic [28:0] rxId, txId;
  logic [3:0] rxDlc, txDlc;
  logic [63:0] rxData, txData;
  int fails = 0;
  int nChecks = 0;
  cmb_row_t rows[9] = '{
    '{8'h70, 16'hA55A, 16'hA55A}, '{8'h73, 16'h0F0F, 16'h0F0F}, '{8'h74, 16'h0007, 16'h0007},
    '{8'h75, 16'h0008, 16'h0008},
    '{8'h77, 16'h9FFF, 16'h9FFF},
    '{8'h76, 16'hBEEF, 16'hBEEF}, '{8'hF1, 16'h0007, 16'h0007},
    '{8'h80, 16'h1234, 16'h0000}, '{8'h0A, 16'h1234, 16'h0000}};
  cmb_msgbuf_ctrl #(.NBUF(8)) u_cmb_msgbuf_ctrl (.sys_clk, .arst_n, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .rxValid, .rxId, .rxIde, .rxDlc, .rxData, .busBusy, .txReq,
    .txId, .txIde, .txRtr, .txDlc, .txData, .txAccept, .txDone, .txOk, .irq);
  cmb_can_node u_cmb_can_node (.sys_clk, .arst_n, .txReq, .holdBusy, .failNext, .txAccept,
    .txDone, .txOk, .busBusy, .rxValid, .rxId, .rxIde, .rxDlc, .rxData);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 check(nm, 64'(regRdata), 64'(e));
  endtask
  task automatic waitOn(input int s);
    for (int i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      #1;
      if ((s == 0 && txReq) || (s == 1 && txAccept) || (s == 2 && txDone) || (s == 3 && rxValid))
        return;
    end
    check("wait", 64'h0, 64'h1);
  endtask
  task automatic rxf(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
    u_cmb_can_node.send({id, 18'h0}, dlc, d);
    waitOn(3);
  endtask
  initial begin
    for (int c = 0; c < 20000; c++) @(posedge sys_clk);
    fails++;
    printVerdict();
  end
  initial begin
    {regAddr, regWdata, regWr, regRd, holdBusy, failNext} = '0;
    arst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1 check("txReq rst", 64'(txReq), 64'h0);
    check("irq rst", 64'(irq), 64'h0);
    rdchk("ctl rst", 8'h08, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdchk("row", rows[i].a, rows[i].e);
    end
    wr(8'h17, 16'h0400);
    wr(8'h15, 16'h0008);
    wr(8'h11, 16'hBBBB);
    wr(8'h12, 16'hCCCC);
    wr(8'h18, 16'h0800);
    wr(8'h18, 16'h0100);
    rxf(11'h100, 4'h3, 64'h8877665544332211);
    rdchk("rx d0", 8'h10, 16'h2211);
    rdchk("rx d1", 8'h11, 16'hBB33);
    rdchk("rx d2", 8'h12, 16'hCCCC);
    rdchk("rx ctl", 8'h18, 16'h000D);
    check("rx irq", 64'(irq), 64'h1);
    wr(8'hF1, 16'h0006);
    check("irq mask", 64'(irq), 64'h0);
    wr(8'hF1, 16'h0007);
    wr(8'hF0, 16'h0001);
    check("irq clr", 64'(irq), 64'h0);
    wr(8'h18, 16'h0004);
    wr(8'h18, 16'h0400);
    rdchk("dn set", 8'h18, 16'h0009);
    rxf(11'h101, 4'h2, 64'h0);
    rdchk("rx miss", 8'h18, 16'h0009);
    rxf(11'h100, 4'hF, 64'h0807060504030201);
    rdchk("rx d3", 8'h13, 16'h0807);
    rxf(11'h100, 4'h0, 64'h0);
    rdchk("dlc0", 8'h10, 16'h0201);
    rdchk("rx mow", 8'h18, 16'h001D);
    wr(8'hF3, 16'h0004);
    wr(8'h27, 16'h0490);
    wr(8'h25, 16'h0010);
    wr(8'h28, 16'h0100);
    rxf(11'h127, 4'h1, 64'h0);
    rdchk("mask miss", 8'h28, 16'h0001);
    rxf(11'h125, 4'h1, 64'h0);
    rdchk("mask hit", 8'h28, 16'h0005);
    rdchk("mask id", 8'h27, 16'h0494);
    wr(8'hF0, 16'h0007);
    wr(8'h07, 16'h0800);
    wr(8'h04, 16'h0002);
    wr(8'h00, 16'h5A5A);
    wr(8'h37, 16'h0400);
    wr(8'h34, 16'h0001);
    wr(8'h30, 16'h00C3);
    wr(8'h38, 16'h0800);
    wr(8'h38, 16'h0100);
    wr(8'h08, 16'h0100);
    holdBusy <= 1'b1;
    wr(8'h08, 16'h0200);
    wr(8'h38, 16'h0200);
    repeat (8) @(posedge sys_clk);
    #1 check("tx held", 64'(txReq), 64'h0);
    holdBusy <= 1'b0;
    waitOn(0);
    check("prio id", 64'(txId), {35'h0, 11'h100, 18'h0});
    check("tx byte", 64'(txData[7:0]), 64'hC3);
    waitOn(1);
    wr(8'h38, 16'h0002);
    waitOn(2);
    failNext <= 1'b1;
    waitOn(0);
    check("next id", 64'(txId), {35'h0, 11'h200, 18'h0});
    check("tx dlc", 64'(txDlc), 64'h2);
    check("tx word", 64'(txData[15:0]), 64'h5A5A);
    wr(8'h08, 16'h0001);
    rdchk("rdy held", 8'h08, 16'h0003);
    waitOn(2);
    failNext <= 1'b0;
    rdchk("retry", 8'h08, 16'h0003);
    rdchk("tx st", 8'hF0, 16'h0002);
    rdchk("tx ctl", 8'h38, 16'h0009);
    waitOn(2);
    rdchk("tx ok", 8'h08, 16'h0001);
    wr(8'h08, 16'h0001);
    rdchk("rdy clr", 8'h08, 16'h0000);
    // Same base identifier three ways: standard data, standard remote, extended data
    wr(8'h47, 16'h0400);
    wr(8'h45, 16'h0040);
    wr(8'h57, 16'h8400);
    wr(8'h67, 16'h0400);
    wr(8'h48, 16'h0100);
    wr(8'h58, 16'h0100);
    wr(8'h68, 16'h0100);
    holdBusy <= 1'b1;
    wr(8'h48, 16'h0200);
    wr(8'h58, 16'h0200);
    wr(8'h68, 16'h0200);
    holdBusy <= 1'b0;
    waitOn(0);
    check("std data", 64'({txIde, txRtr}), 64'h0);
    waitOn(2);
    waitOn(0);
    check("std remote", 64'({txIde, txRtr}), 64'h1);
    waitOn(2);
    waitOn(0);
    check("ext data", 64'({txIde, txRtr}), 64'h2);
    printVerdict();
  end
endmodule
